// file: shared/pid_pkg.sv
// Package: opcodes, field positions and decode types for the privileged decoder
`default_nettype none
package pid_pkg;
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 26;
  localparam int FA_HI = 25;
  localparam int FA_LO = 21;
  localparam int FB_HI = 20;
  localparam int FB_LO = 16;
  localparam int TYPE_HI = 15;
  localparam int TYPE_LO = 13;
  localparam int SIZE_BIT = 12;
  localparam int OFS12_HI = 11;
  localparam int HINT_HI = 15;
  localparam int HINT_LO = 14;
  localparam int STALL_BIT = 13;
  localparam int OFS13_HI = 12;
  localparam int IDX_HI = 15;
  localparam int IDX_LO = 8;
  localparam int MASK_HI = 7;
  localparam int FWMODE_BIT = 0;
  localparam int SCBD_W = 8;
  localparam int IMB_LOW_SCBD = 4;

  localparam logic [5:0] OPC_CALL = 6'h00;
  localparam logic [5:0] OPC_LOAD = 6'h1b;
  localparam logic [5:0] OPC_STORE = 6'h1f;
  localparam logic [5:0] OPC_RET = 6'h1e;
  localparam logic [5:0] OPC_RDREG = 6'h19;
  localparam logic [5:0] OPC_WRREG = 6'h1d;

  localparam logic [25:0] FN_HALT = 26'h0000000;
  localparam logic [25:0] FN_DRAIN = 26'h0000002;
  localparam logic [25:0] FN_IMB = 26'h0000086;

  localparam logic [4:0] REG_ZERO = 5'h1f;

  localparam logic [2:0] LD_PHYS = 3'h0;
  localparam logic [2:0] LD_PHYS_LOCK = 3'h1;
  localparam logic [2:0] VIRTUAL_PAGE_ENTRY_FETCH = 3'h2;
  localparam logic [2:0] LD_VIRT = 3'h4;
  localparam logic [2:0] LD_VIRT_WCHK = 3'h5;
  localparam logic [2:0] LD_VIRT_ALT = 3'h6;
  localparam logic [2:0] LD_VIRT_WCHK_ALT = 3'h7;
  localparam logic [2:0] ST_PHYS = 3'h0;
  localparam logic [2:0] ST_PHYS_COND = 3'h1;
  localparam logic [2:0] ST_VIRT = 3'h2;
  localparam logic [2:0] ST_VIRT_ALT = 3'h6;

  localparam logic [1:0] HINT_JMP = 2'h0;
  localparam logic [1:0] HINT_CALL = 2'h1;
  localparam logic [1:0] HINT_POP = 2'h2;
  localparam logic [1:0] HINT_POPPUSH = 2'h3;

  typedef enum logic [3:0] {
    PID_OP_NONE, PID_OP_HALT, PID_OP_DRAIN, PID_OP_IMB, PID_OP_CALL_OTHER,
    PID_OP_LOAD, PID_OP_STORE, PID_OP_RET, PID_OP_RDREG, PID_OP_WRREG, PID_OP_TRAP
  } pid_op_e;
endpackage : pid_pkg
`default_nettype wire

// file: shared/pid_if.sv
// Interface between fetch-side issuer and privileged decoder
`default_nettype none
interface pid_if;
  logic        instr_valid;
  logic [31:0] instr;
  logic [63:0] pc;
  logic [63:0] regb_value;
  logic        firmware_mode;
  logic        kernel_mode;
  logic        kernel_priv_instr_enable;
  logic [1:0]  alternate_translation_mode;
  logic [1:0]  current_mode;
  logic        retire;
  logic        abort;
  logic        stall_fetch;
  logic        dec_valid;
  logic [3:0]  dec_op;
  logic        reserved_opcode_trap;
  modport device (
    input  instr_valid, instr, pc, regb_value, firmware_mode, kernel_mode,
           kernel_priv_instr_enable, alternate_translation_mode, current_mode, retire, abort,
    output stall_fetch, dec_valid, dec_op, reserved_opcode_trap
  );
  modport host (
    output instr_valid, instr, pc, regb_value, firmware_mode, kernel_mode,
           kernel_priv_instr_enable, alternate_translation_mode, current_mode, retire, abort,
    input  stall_fetch, dec_valid, dec_op, reserved_opcode_trap
  );
endinterface : pid_if
`default_nettype wire

// file: hdl/pid_scoreboard.sv
// Eight-bit internal register scoreboard gating issue-queue entry
`default_nettype none
module pid_scoreboard #(
  parameter int W = pid_pkg::SCBD_W
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_resetn,
  input  wire logic         i_enter_req,
  input  wire logic [W-1:0] i_mask,
  input  wire logic         i_issue,
  input  wire logic         i_retire,
  input  wire logic [W-1:0] i_clear_mask,
  output logic              o_stall,
  output logic [W-1:0]      o_bits
);
  logic [W-1:0] bits_q;
  assign o_bits = bits_q;
  assign o_stall = i_enter_req && |(bits_q & i_mask); // [RQ22]

  // Low half clears on issue, upper half on retire or abort
  for (genvar k = 0; k < W; k++)
  begin : g_bit
    logic clr_ev;
    assign clr_ev = i_clear_mask[k] && ((k < pid_pkg::IMB_LOW_SCBD) ? i_issue : i_retire);
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
      if (!i_resetn)
        bits_q[k] <= 1'b0;
      else if (i_enter_req && !o_stall && i_mask[k])
        bits_q[k] <= 1'b1; // [RQ22]
      else if (clr_ev)
        bits_q[k] <= 1'b0;
    end
  end
endmodule : pid_scoreboard
`default_nettype wire

// file: hdl/pid_decoder.sv
// Device end: privileged instruction decode, privilege check, return control
`default_nettype none
// Summary of operation
// RQ1: Decode halt, drain aborts, memory barrier calls
// RQ2: Opcodes 1B 1F 1E 19 1D are privileged
// RQ3: Trap privileged opcodes outside firmware mode
// RQ4: Kernel enable bit allows them in kernel
// RQ5: Privileged load/store never raise alignment traps
// RQ6: Load fields: reg, base, type, size, offset
// RQ7: Load types physical, lock, page fetch, virtual
// RQ8: Write-check types check read/write faults
// RQ9: Alternate types use alternate translation mode
// RQ10: Store types physical, conditional, virtual, alternate
// RQ11: Return target from register, bit0 sets mode
// RQ12: Hint bits drive prediction stack push/pop
// RQ13: Firmware returns use pop hint
// RQ14: Retire-only returns use no-push hint
// RQ15: Stall bit forces mispredict and holds fetch
// RQ16: Stall kills and refetches issued younger instructions
// RQ17: Thirteen-bit signed longword offset for prediction
// RQ18: Return first register field is register 31
// RQ19: Register read/write move internal register values
// RQ20: Low byte selects scoreboard bits
// RQ21: Unused register field is register 31
// RQ22: Stall entry until selected bits clear, then set
// RQ23: Undefined store types decode as unused
module pid_decoder (
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  pid_if.device            bus,
  input  wire logic        i_issue,
  output logic [4:0]       o_first_reg,
  output logic [4:0]       o_second_reg,
  output logic [2:0]       o_access_type,
  output logic             o_access_size_bit,
  output logic [63:0]      o_offset,
  output logic             o_physical,
  output logic             o_lock,
  output logic             o_page_entry_fetch,
  output logic             o_write_check,
  output logic [1:0]       o_check_mode,
  output logic             o_store_unused,
  output logic             o_align_trap_disable,
  output logic [7:0]       o_ipr_index,
  output logic [7:0]       o_scoreboard_select_field,
  output logic             o_ret_valid,
  output logic [63:0]      o_ret_target,
  output logic             o_new_firmware_mode,
  output logic [63:0]      o_predicted_target,
  output logic             o_stack_push,
  output logic             o_stack_pop,
  output logic             o_force_mispredict,
  output logic             o_kill_younger
);
  logic [31:0] ins;
  logic [5:0]  opc;
  logic [2:0]  typ;
  logic        priv_opc;
  logic        allowed;
  logic        stall_enter;
  logic        is_scbd;
  logic        sb_stall;
  logic        offer;
  logic        ret_hold_q;
  logic [7:0]  sb_clr_q;
  pid_pkg::pid_op_e op_d;

  assign ins = bus.instr;
  assign opc = ins[pid_pkg::OPC_HI:pid_pkg::OPC_LO];
  assign typ = ins[pid_pkg::TYPE_HI:pid_pkg::TYPE_LO];
  assign priv_opc = (opc == pid_pkg::OPC_LOAD) || (opc == pid_pkg::OPC_STORE) ||
                    (opc == pid_pkg::OPC_RET) || (opc == pid_pkg::OPC_RDREG) ||
                    (opc == pid_pkg::OPC_WRREG); // [RQ2]
  assign allowed = bus.firmware_mode ||
                   (bus.kernel_mode && bus.kernel_priv_instr_enable); // [RQ3] [RQ4]
  assign is_scbd = (opc == pid_pkg::OPC_RDREG) || (opc == pid_pkg::OPC_WRREG);
  // Word stays on the bus the cycle after it is taken; never take it twice
  assign offer = bus.instr_valid && !bus.dec_valid;

  always_comb
  begin
    op_d = pid_pkg::PID_OP_NONE;
    if (priv_opc && !allowed)
      op_d = pid_pkg::PID_OP_TRAP; // [RQ3]
    else
    begin
      unique case (opc)
        pid_pkg::OPC_CALL:
          unique case (ins[25:0])
            pid_pkg::FN_HALT:  op_d = pid_pkg::PID_OP_HALT;  // [RQ1]
            pid_pkg::FN_DRAIN: op_d = pid_pkg::PID_OP_DRAIN; // [RQ1]
            pid_pkg::FN_IMB:   op_d = pid_pkg::PID_OP_IMB;   // [RQ1]
            default:           op_d = pid_pkg::PID_OP_CALL_OTHER;
          endcase
        pid_pkg::OPC_LOAD:  op_d = pid_pkg::PID_OP_LOAD;
        pid_pkg::OPC_STORE: op_d = pid_pkg::PID_OP_STORE;
        pid_pkg::OPC_RET:   op_d = pid_pkg::PID_OP_RET;
        pid_pkg::OPC_RDREG: op_d = pid_pkg::PID_OP_RDREG;
        pid_pkg::OPC_WRREG: op_d = pid_pkg::PID_OP_WRREG;
        default:            op_d = pid_pkg::PID_OP_NONE;
      endcase
      // Halt and drain are privileged calls; barrier is not
      if ((op_d == pid_pkg::PID_OP_HALT || op_d == pid_pkg::PID_OP_DRAIN) && !allowed)
        op_d = pid_pkg::PID_OP_TRAP; // [RQ1]
    end
  end

  // Scoreboard entry gate for internal register moves
  pid_scoreboard #(.W(pid_pkg::SCBD_W)) u_sb (
    .i_clk_sys   (i_clk_sys),
    .i_resetn    (i_resetn),
    .i_enter_req (offer && is_scbd && allowed && !ret_hold_q),
    .i_mask      (ins[pid_pkg::MASK_HI:0]), // [RQ20]
    .i_issue     (i_issue),
    .i_retire    (bus.retire || bus.abort),
    .i_clear_mask(sb_clr_q),
    .o_stall     (sb_stall),
    .o_bits      ()
  );

  assign stall_enter = offer && !sb_stall && !ret_hold_q;

  // Remember which bits the last accepted register read or write set, for clearing
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      sb_clr_q <= '0;
    else if (stall_enter && is_scbd && allowed)
      sb_clr_q <= ins[pid_pkg::MASK_HI:0];
  end

  // Fetch hold from stalled return until retire or abort
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      ret_hold_q <= 1'b0;
    else if (bus.retire || bus.abort)
      ret_hold_q <= 1'b0;
    else if (stall_enter && op_d == pid_pkg::PID_OP_RET && ins[pid_pkg::STALL_BIT])
      ret_hold_q <= 1'b1; // [RQ15]
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      bus.stall_fetch <= 1'b0;
      bus.dec_valid <= 1'b0;
      bus.dec_op <= 4'h0;
      bus.reserved_opcode_trap <= 1'b0;
    end
    else
    begin
      bus.stall_fetch <= (bus.instr_valid && sb_stall) ||
                         (ret_hold_q && !(bus.retire || bus.abort)) ||
                         (stall_enter && op_d == pid_pkg::PID_OP_RET &&
                          ins[pid_pkg::STALL_BIT]); // [RQ15] [RQ22]
      bus.dec_valid <= stall_enter;
      bus.dec_op <= op_d;
      bus.reserved_opcode_trap <= stall_enter && op_d == pid_pkg::PID_OP_TRAP; // [RQ3]
    end
  end

  // Field extraction, registered once per accepted instruction
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_first_reg <= 5'h00;
      o_second_reg <= 5'h00;
      o_access_type <= 3'h0;
      o_access_size_bit <= 1'b0;
      o_offset <= 64'h0;
      o_physical <= 1'b0;
      o_lock <= 1'b0;
      o_page_entry_fetch <= 1'b0;
      o_write_check <= 1'b0;
      o_check_mode <= 2'h0;
      o_store_unused <= 1'b0;
      o_align_trap_disable <= 1'b0;
      o_ipr_index <= 8'h00;
      o_scoreboard_select_field <= 8'h00;
    end
    else if (stall_enter)
    begin
      o_first_reg <= ins[pid_pkg::FA_HI:pid_pkg::FA_LO]; // [RQ6] [RQ10] [RQ19]
      o_second_reg <= ins[pid_pkg::FB_HI:pid_pkg::FB_LO]; // [RQ6] [RQ19]
      o_access_type <= typ;
      o_access_size_bit <= ins[pid_pkg::SIZE_BIT]; // [RQ6]
      o_offset <= {{52{ins[pid_pkg::OFS12_HI]}}, ins[pid_pkg::OFS12_HI:0]}; // [RQ6]
      o_ipr_index <= ins[pid_pkg::IDX_HI:pid_pkg::IDX_LO]; // [RQ19]
      o_scoreboard_select_field <= ins[pid_pkg::MASK_HI:0]; // [RQ20]
      o_align_trap_disable <= (op_d == pid_pkg::PID_OP_LOAD) ||
                              (op_d == pid_pkg::PID_OP_STORE); // [RQ5]
      o_check_mode <= bus.current_mode;
      o_physical <= 1'b0;
      o_lock <= 1'b0;
      o_page_entry_fetch <= 1'b0;
      o_write_check <= 1'b0;
      o_store_unused <= 1'b0;
      if (op_d == pid_pkg::PID_OP_LOAD)
      begin
        o_physical <= (typ == pid_pkg::LD_PHYS) || (typ == pid_pkg::LD_PHYS_LOCK); // [RQ7]
        o_lock <= (typ == pid_pkg::LD_PHYS_LOCK); // [RQ7]
        o_page_entry_fetch <= (typ == pid_pkg::VIRTUAL_PAGE_ENTRY_FETCH); // [RQ7]
        o_write_check <= (typ == pid_pkg::LD_VIRT_WCHK) ||
                         (typ == pid_pkg::LD_VIRT_WCHK_ALT); // [RQ8]
        if (typ == pid_pkg::LD_VIRT_ALT || typ == pid_pkg::LD_VIRT_WCHK_ALT)
          o_check_mode <= bus.alternate_translation_mode; // [RQ9]
      end
      else if (op_d == pid_pkg::PID_OP_STORE)
      begin
        o_physical <= (typ == pid_pkg::ST_PHYS) || (typ == pid_pkg::ST_PHYS_COND); // [RQ10]
        o_lock <= (typ == pid_pkg::ST_PHYS_COND); // [RQ10]
        o_store_unused <= !(typ == pid_pkg::ST_PHYS || typ == pid_pkg::ST_PHYS_COND ||
                            typ == pid_pkg::ST_VIRT || typ == pid_pkg::ST_VIRT_ALT); // [RQ23]
        if (typ == pid_pkg::ST_VIRT_ALT)
          o_check_mode <= bus.alternate_translation_mode; // [RQ9]
      end
    end
  end

  // Return control: target, mode, stack action, mispredict
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_ret_valid <= 1'b0;
      o_ret_target <= 64'h0;
      o_new_firmware_mode <= 1'b0;
      o_predicted_target <= 64'h0;
      o_stack_push <= 1'b0;
      o_stack_pop <= 1'b0;
      o_force_mispredict <= 1'b0;
      o_kill_younger <= 1'b0;
    end
    else
    begin
      o_ret_valid <= stall_enter && op_d == pid_pkg::PID_OP_RET;
      o_stack_push <= 1'b0;
      o_stack_pop <= 1'b0;
      o_force_mispredict <= 1'b0;
      o_kill_younger <= 1'b0;
      if (stall_enter && op_d == pid_pkg::PID_OP_RET)
      begin
        o_ret_target <= {bus.regb_value[63:1], 1'b0}; // [RQ11]
        o_new_firmware_mode <= bus.regb_value[pid_pkg::FWMODE_BIT]; // [RQ11]
        o_predicted_target <= bus.pc + {{49{ins[pid_pkg::OFS13_HI]}},
                              ins[pid_pkg::OFS13_HI:0], 2'b00}; // [RQ17]
        unique case (ins[pid_pkg::HINT_HI:pid_pkg::HINT_LO])
          pid_pkg::HINT_JMP:     ;
          pid_pkg::HINT_CALL:    o_stack_push <= 1'b1; // [RQ12]
          pid_pkg::HINT_POP:     o_stack_pop <= 1'b1; // [RQ12] [RQ13]
          pid_pkg::HINT_POPPUSH:
          begin
            o_stack_pop <= 1'b1; // [RQ12]
            o_stack_push <= 1'b1;
          end
        endcase
        o_force_mispredict <= ins[pid_pkg::STALL_BIT]; // [RQ15]
        o_kill_younger <= ins[pid_pkg::STALL_BIT]; // [RQ16]
      end
    end
  end
endmodule : pid_decoder
`default_nettype wire

// file: hdl/pid_issuer.sv
// Host end: presents instructions and mode state, holds while stalled
`default_nettype none
module pid_issuer (
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  pid_if.host              bus,
  input  wire logic        i_valid,
  input  wire logic [31:0] i_instr,
  input  wire logic [63:0] i_pc,
  input  wire logic [63:0] i_regb_value,
  input  wire logic        i_firmware_mode,
  input  wire logic        i_kernel_mode,
  input  wire logic        i_kernel_priv_instr_enable,
  input  wire logic [1:0]  i_alternate_translation_mode,
  input  wire logic [1:0]  i_current_mode,
  input  wire logic        i_retire,
  input  wire logic        i_abort,
  output logic             o_ready,
  output logic             o_trap,
  output logic [3:0]       o_op
);
  logic busy_q;

  // Load a new instruction only when the slot is free or the decoder took it
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      busy_q <= 1'b0;
      bus.instr_valid <= 1'b0;
      bus.instr <= 32'h0;
      bus.pc <= 64'h0;
      bus.regb_value <= 64'h0;
    end
    else if (!busy_q || bus.dec_valid)
    begin
      busy_q <= i_valid;
      bus.instr_valid <= i_valid;
      bus.instr <= i_instr; // [RQ13] [RQ14] [RQ18] [RQ21]
      bus.pc <= i_pc;
      bus.regb_value <= i_regb_value;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      bus.firmware_mode <= 1'b1;
      bus.kernel_mode <= 1'b0;
      bus.kernel_priv_instr_enable <= 1'b0;
      bus.alternate_translation_mode <= 2'h0;
      bus.current_mode <= 2'h0;
      bus.retire <= 1'b0;
      bus.abort <= 1'b0;
      o_ready <= 1'b0;
      o_trap <= 1'b0;
      o_op <= 4'h0;
    end
    else
    begin
      bus.firmware_mode <= i_firmware_mode;
      bus.kernel_mode <= i_kernel_mode;
      bus.kernel_priv_instr_enable <= i_kernel_priv_instr_enable;
      bus.alternate_translation_mode <= i_alternate_translation_mode;
      bus.current_mode <= i_current_mode;
      bus.retire <= i_retire;
      bus.abort <= i_abort;
      o_ready <= !busy_q || bus.dec_valid;
      o_trap <= bus.reserved_opcode_trap;
      o_op <= bus.dec_op;
    end
  end
endmodule : pid_issuer
`default_nettype wire

// file: verif/pid_asserts.sv
// Checker on the link between issuer and privileged decoder
`default_nettype none
module pid_asserts (
  input wire logic        i_clk_sys,
  input wire logic        i_resetn,
  input wire logic        instr_valid,
  input wire logic [31:0] instr,
  input wire logic        firmware_mode,
  input wire logic        kernel_mode,
  input wire logic        kernel_priv_instr_enable,
  input wire logic        retire,
  input wire logic        abort,
  input wire logic        stall_fetch,
  input wire logic        dec_valid,
  input wire logic [3:0]  dec_op,
  input wire logic        reserved_opcode_trap
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);
  logic priv_w;
  logic bit13_q;
  logic hold_q;
  assign priv_w = instr[31:26] inside {6'h1b, 6'h1f, 6'h1e, 6'h19, 6'h1d};
  always_ff @(posedge i_clk_sys or negedge i_resetn)
    if (!i_resetn)
      bit13_q <= 1'b0;
    else
      bit13_q <= instr[13];
  // Mirrors the return hold so acceptance during it can be caught
  always_ff @(posedge i_clk_sys or negedge i_resetn)
    if (!i_resetn)
      hold_q <= 1'b0;
    else if (retire || abort)
      hold_q <= 1'b0;
    else if (dec_valid && dec_op == pid_pkg::PID_OP_RET && bit13_q)
      hold_q <= 1'b1;
  a_trap_cause: assert property (dec_valid && $past(priv_w) |->
    reserved_opcode_trap == !($past(firmware_mode) ||
    ($past(kernel_mode) && $past(kernel_priv_instr_enable))))
    else $error("trap flag disagrees with privilege state");
  a_trap_pulse: assert property (reserved_opcode_trap |->
    dec_valid && dec_op == pid_pkg::PID_OP_TRAP)
    else $error("trap without trap decode");
  a_priv_decode: assert property (dec_valid && $past(priv_w && firmware_mode) |->
    !reserved_opcode_trap && dec_op inside {[4'h5 : 4'h9]})
    else $error("firmware privileged opcode not decoded");
  a_valid_cause: assert property (dec_valid |-> $past(instr_valid))
    else $error("decode without instruction");
  a_barrier_free: assert property (dec_valid && $past(instr) == 32'h00000086 |->
    dec_op == pid_pkg::PID_OP_IMB && !reserved_opcode_trap)
    else $error("barrier call misdecoded");
  a_ret_stall: assert property (dec_valid && dec_op == pid_pkg::PID_OP_RET && bit13_q |->
    stall_fetch)
    else $error("stall return did not hold fetch");
  a_stall_holds: assert property (hold_q && !retire && !abort |=> stall_fetch)
    else $error("fetch released before retire");
  a_no_take_held: assert property (dec_valid |-> !$past(hold_q && !retire && !abort))
    else $error("instruction taken during return hold");
endmodule : pid_asserts
`default_nettype wire

// file: verif/tb.sv
// Bench: issuer and decoder joined, every decode compared with a model
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk_sys, i_resetn, i_valid, i_issue, i_retire, i_abort, o_ready, o_trap;
  logic [3:0]  o_op;
  logic        i_firmware_mode, i_kernel_mode, i_kernel_priv_instr_enable;
  logic [1:0]  i_alternate_translation_mode, i_current_mode, o_check_mode;
  logic [31:0] i_instr, ins;
  logic [63:0] i_pc, i_regb_value, o_offset, o_ret_target, o_predicted_target;
  logic [4:0]  o_first_reg, o_second_reg;
  logic [2:0]  o_access_type;
  logic [7:0]  o_ipr_index, o_scoreboard_select_field;
  logic        o_access_size_bit, o_physical, o_lock, o_page_entry_fetch, o_write_check;
  logic        o_store_unused, o_align_trap_disable, o_ret_valid, o_new_firmware_mode;
  logic        o_stack_push, o_stack_pop, o_force_mispredict, o_kill_younger;
  int          errors, n_tests, seed;
  bit          got;
  logic [5:0]  opc_tab [7] = '{6'h00, 6'h1b, 6'h1f, 6'h1e, 6'h19, 6'h1d, 6'h10};
  logic [25:0] fn_tab [4] = '{26'h0, 26'h2, 26'h86, 26'h5};
  pid_if bus_if ();
  pid_decoder pid_decoder_i (.i_clk_sys, .i_resetn, .bus(bus_if), .i_issue, .o_first_reg,
    .o_second_reg, .o_access_type, .o_access_size_bit, .o_offset, .o_physical, .o_lock,
    .o_page_entry_fetch, .o_write_check, .o_check_mode, .o_store_unused,
    .o_align_trap_disable, .o_ipr_index, .o_scoreboard_select_field, .o_ret_valid,
    .o_ret_target, .o_new_firmware_mode, .o_predicted_target, .o_stack_push, .o_stack_pop,
    .o_force_mispredict, .o_kill_younger);
  pid_issuer pid_issuer_i (.i_clk_sys, .i_resetn, .bus(bus_if), .i_valid, .i_instr, .i_pc,
    .i_regb_value, .i_firmware_mode, .i_kernel_mode, .i_kernel_priv_instr_enable,
    .i_alternate_translation_mode, .i_current_mode, .i_retire, .i_abort, .o_ready,
    .o_trap, .o_op);
  pid_asserts pid_asserts_i (.i_clk_sys, .i_resetn, .instr_valid(bus_if.instr_valid),
    .instr(bus_if.instr), .firmware_mode(bus_if.firmware_mode),
    .kernel_mode(bus_if.kernel_mode), .kernel_priv_instr_enable(bus_if.kernel_priv_instr_enable),
    .retire(bus_if.retire), .abort(bus_if.abort), .stall_fetch(bus_if.stall_fetch),
    .dec_valid(bus_if.dec_valid), .dec_op(bus_if.dec_op),
    .reserved_opcode_trap(bus_if.reserved_opcode_trap));
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic pulse(input logic [2:0] r);
    {i_issue, i_retire, i_abort} = r;
    @(negedge i_clk_sys);
    {i_issue, i_retire, i_abort} = 3'h0;
  endtask : pulse
  task automatic issue(input logic [31:0] w);
    int k;
    k = 0;
    while (o_ready !== 1'b1 && k < 20)
    begin
      @(negedge i_clk_sys);
      k++;
    end
    if (k == 20)
    begin
      errors++;
      wrap_up();
    end
    i_instr = w;
    i_pc = {$random(seed), $random(seed)};
    i_regb_value = {$random(seed), $random(seed)};
    i_valid = 1'b1;
    @(negedge i_clk_sys);
    i_valid = 1'b0;
  endtask : issue
  task automatic wait_dec(input bit must, input int lim);
    logic [2:0] ty;
    logic [3:0] eop;
    logic       ld, st, tr;
    got = 0;
    for (int k = 0; k < lim && !got; k++)
    begin
      @(negedge i_clk_sys);
      got = bus_if.dec_valid === 1'b1;
    end
    if (!got && must)
    begin
      errors++;
      wrap_up();
    end
    if (!got)
      return;
    ty = i_instr[15:13];
    case (i_instr[31:26])
      pid_pkg::OPC_CALL:  eop = 4'(i_instr[25:0] == 26'h0 ? 1 : i_instr[25:0] == 26'h2 ? 2 :
                                   i_instr[25:0] == 26'h86 ? 3 : 4);
      pid_pkg::OPC_LOAD:  eop = pid_pkg::PID_OP_LOAD;
      pid_pkg::OPC_STORE: eop = pid_pkg::PID_OP_STORE;
      pid_pkg::OPC_RET:   eop = pid_pkg::PID_OP_RET;
      pid_pkg::OPC_RDREG: eop = pid_pkg::PID_OP_RDREG;
      pid_pkg::OPC_WRREG: eop = pid_pkg::PID_OP_WRREG;
      default:            eop = pid_pkg::PID_OP_NONE;
    endcase
    tr = eop inside {4'h1, 4'h2, [4'h5 : 4'h9]} && !i_firmware_mode &&
         !(i_kernel_mode && i_kernel_priv_instr_enable);
    if (tr)
      eop = pid_pkg::PID_OP_TRAP;
    // A trapped load or store carries none of the access flags
    ld = eop == pid_pkg::PID_OP_LOAD;
    st = eop == pid_pkg::PID_OP_STORE;
    chk("op", bus_if.dec_op, eop);
    chk("trap", bus_if.reserved_opcode_trap, tr);
    chk("ret", o_ret_valid, eop == pid_pkg::PID_OP_RET);
    if (eop inside {[4'h5 : 4'h6], [4'h8 : 4'h9]})
    begin
      chk("ra", o_first_reg, i_instr[25:21]);
      chk("rb", o_second_reg, i_instr[20:16]);
    end
    if (eop inside {4'h8, 4'h9})
    begin
      chk("idx", o_ipr_index, i_instr[15:8]);
      chk("mask", o_scoreboard_select_field, i_instr[7:0]);
    end
    if (ld || st)
    begin
      chk("type", o_access_type, ty);
      chk("size", o_access_size_bit, i_instr[12]);
      chk("ofs", o_offset, {{52{i_instr[11]}}, i_instr[11:0]});
      chk("noalign", o_align_trap_disable, 1'b1);
      chk("unused", o_store_unused, st && !(ty inside {0, 1, 2, 6}));
      if (ty < 3'h3 || ty == 3'h6 || (ld && ty[2]))
        chk("phys", o_physical, ty < 3'h2);
      if ((ld && ty[2]) || (st && ty[1] && !ty[0]))
        chk("mode", o_check_mode, ty[2:1] == 2'h3 ? i_alternate_translation_mode :
            i_current_mode);
    end
    if (ld)
    begin
      chk("lock", o_lock, ty == 3'h1);
      chk("pte", o_page_entry_fetch, ty == 3'h2);
      chk("wchk", o_write_check, ty == 3'h5 || ty == 3'h7);
    end
    if (eop == pid_pkg::PID_OP_RET)
    begin
      chk("tgt", o_ret_target, {i_regb_value[63:1], 1'b0});
      chk("fwm", o_new_firmware_mode, i_regb_value[0]);
      chk("push", o_stack_push, i_instr[14]);
      chk("pop", o_stack_pop, i_instr[15]);
      chk("misp", o_force_mispredict, i_instr[13]);
      chk("kill", o_kill_younger, i_instr[13]);
      chk("hold", bus_if.stall_fetch, i_instr[13]);
      if (!i_instr[15])
        chk("pred", o_predicted_target,
            i_pc + {{49{i_instr[12]}}, i_instr[12:0], 2'b00});
    end
    @(negedge i_clk_sys);
    chk("otrap", o_trap, tr);
    chk("oop", o_op, eop);
  endtask : wait_dec
  // Second word must wait on the first; f of zero means a held return
  task automatic blocked(input logic [31:0] b, input logic [31:0] f, input logic [2:0] rel);
    issue(b);
    wait_dec(1, 8);
    if (f != 0)
    begin
      issue(f);
      wait_dec(0, 6);
      chk("early", got, 1'b0);
      chk("sfull", bus_if.stall_fetch, 1'b1);
    end
    else
      repeat (5)
      begin
        @(negedge i_clk_sys);
        chk("held", bus_if.stall_fetch, 1'b1);
      end
    pulse(rel);
    if (f != 0)
      wait_dec(1, 8);
    else
    begin
      repeat (3) @(negedge i_clk_sys);
      chk("free", bus_if.stall_fetch, 1'b0);
    end
    pulse(3'h7);
  endtask : blocked
  initial
  begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  initial
  begin
    errors = 0;
    n_tests = 0;
    seed = 32'haa676387;
    i_resetn = 1'b0;
    {i_valid, i_issue, i_retire, i_abort} = 4'h0;
    {i_instr, i_pc, i_regb_value} = '0;
    {i_firmware_mode, i_kernel_mode, i_kernel_priv_instr_enable} = 3'h4;
    {i_alternate_translation_mode, i_current_mode} = 4'h0;
    repeat (8) @(negedge i_clk_sys);
    chk("rst_fw", bus_if.firmware_mode, 1'b1);
    chk("rst_dv", bus_if.dec_valid, 1'b0);
    i_resetn = 1'b1;
    for (int i = 0; i < 112; i++)
    begin
      ins = $random(seed);
      ins[31:26] = opc_tab[i % 7];
      ins[15:13] = 3'((i / 7) % 8);
      {i_firmware_mode, i_kernel_mode, i_kernel_priv_instr_enable} = 3'($random(seed));
      {i_alternate_translation_mode, i_current_mode} = 4'($random(seed));
      if (ins[31:26] == 6'h00)
      begin
        ins[25:0] = fn_tab[(i / 7) % 4];
        i_kernel_mode = 1'b0;
      end
      if (ins[31:26] == 6'h1e || ins[31:26] == 6'h1d)
        ins[25:21] = 5'h1f;
      if (ins[31:26] == 6'h19)
        ins[20:16] = 5'h1f;
      issue(ins);
      wait_dec(1, 8);
      pulse(3'h6);
    end
    i_firmware_mode = 1'b1;
    blocked(32'h77e21001, 32'h647f2003, 3'h4);
    blocked(32'h77e23010, 32'h647f4030, 3'h2);
    blocked(32'h77e25020, 32'h647f6020, 3'h1);
    blocked(32'h7be3a000, 32'h0, 3'h2);
    blocked(32'h7be32004, 32'h0, 3'h1);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
